// [rtl/tcs_flag_bank.sv]
// per-slot sticky signalling change flags, cleared when their register is read
`include "tcs_cfg.svh"
module tcs_flag_bank
  import tcs_pkg::*;
#(
  parameter int SLOTS = `TCS_SLOTS
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             cas_en_i,
  input  wire logic [SLOTS-1:0] change_i,
  tcs_rd_if.bank                rd
);
  logic [SLOTS-1:0] flag_q;
  logic [SLOTS-1:0] flag_d;
  logic [SLOTS-1:0] clr;

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      // slot 0 of each group of eight sits in bit 7
      if (g / `TCS_SLOTS_PER_REG == 0) begin : g_r0
        assign clr[g] = rd.rd_chg0;
      end else if (g / `TCS_SLOTS_PER_REG == 1) begin : g_r1
        assign clr[g] = rd.rd_chg1;
      end else begin : g_r2
        assign clr[g] = rd.rd_chg2;
      end
    end
  endgenerate

  always_comb begin
    // set beats clear so a change during the read is kept for the next one
    // leaving cas mode drops stale flags so they never read back outside it
    flag_d = cas_en_i ? ((flag_q & ~clr) | change_i) : '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign rd.flags = flag_q;
endmodule : tcs_flag_bank

// [rtl/tcs_frame_mon.sv]
// registers the framer state and flags its transitions
module tcs_frame_mon (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic in_frame_i,
  output logic      in_frame_o,
  output logic      lof_ev_o,
  output logic      inf_ev_o
);
  logic in_frame_q;
  logic in_frame_d;

  always_comb begin
    in_frame_d = in_frame_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_frame_q <= 1'b0;
    end else begin
      in_frame_q <= in_frame_d;
    end
  end

  assign in_frame_o = in_frame_q;
  assign lof_ev_o   = in_frame_q & ~in_frame_i;
  assign inf_ev_o   = ~in_frame_q & in_frame_i;
endmodule : tcs_frame_mon

// [rtl/tcs_status_regs.sv]
// wishbone register bank: cas change flags, frame status, interrupts
`include "tcs_cfg.svh"

module tcs_status_regs
  import tcs_pkg::*;
#(
  parameter int SLOTS = `TCS_SLOTS
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [`TCS_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  output logic                        wb_err_o,
  input  wire logic [SLOTS-1:0]       sig_change_i,
  input  wire logic                   in_frame_i,
  output logic                        cas_mode_o,
  output logic                        irq_o
);
  tcs_rd_if rd ();

  tcs_bus_state_t st_q;
  tcs_bus_state_t st_d;
  logic [31:0]    dat_q;
  logic [31:0]    dat_d;
  logic           err_q;
  logic           err_d;
  logic [2:0]     stat_q;
  logic [2:0]     stat_d;
  logic [2:0]     mask_q;
  logic [2:0]     mask_d;
  logic           cas_q;
  logic           cas_d;
  logic           irq_q;
  logic           irq_d;
  logic           in_frame;
  logic           lof_ev;
  logic           inf_ev;
  logic           req;
  logic           wr_stb;
  logic           rd_stb;
  logic [2:0]     ev;
  tcs_byte_t      chg0;
  tcs_byte_t      chg1;
  tcs_byte_t      chg2;

  tcs_flag_bank #(
    .SLOTS(SLOTS)
  ) u_bank (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cas_en_i(cas_q),
    .change_i(sig_change_i),
    .rd      (rd.bank)
  );

  tcs_frame_mon u_mon (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .in_frame_i(in_frame_i),
    .in_frame_o(in_frame),
    .lof_ev_o  (lof_ev),
    .inf_ev_o  (inf_ev)
  );

  // slot n goes to bit 7-(n mod 8)
  always_comb begin
    for (int i = 0; i < `TCS_SLOTS_PER_REG; i++) begin
      chg0[7-i] = rd.flags[i];
      chg1[7-i] = rd.flags[`TCS_SLOTS_PER_REG+i];
      chg2[7-i] = rd.flags[2*`TCS_SLOTS_PER_REG+i];
    end
  end

  assign req    = wb_cyc_i & wb_stb_i & (st_q == TCS_IDLE);
  assign wr_stb = req & wb_we_i & wb_sel_i[0];
  assign rd_stb = req & ~wb_we_i;

  // the clear fires on the cycle the read data is captured
  assign rd.rd_chg0 = rd_stb & (wb_adr_i == `TCS_OFF_CHG0);
  assign rd.rd_chg1 = rd_stb & (wb_adr_i == `TCS_OFF_CHG1);
  assign rd.rd_chg2 = rd_stb & (wb_adr_i == `TCS_OFF_CHG2);

  always_comb begin
    ev = '0;
    ev[`TCS_IRQ_CHG_BIT] = |(sig_change_i) & cas_q;
    ev[`TCS_IRQ_LOF_BIT] = lof_ev;
    ev[`TCS_IRQ_INF_BIT] = inf_ev;
  end

  always_comb begin
    st_d   = st_q;
    dat_d  = dat_q;
    err_d  = 1'b0;
    mask_d = mask_q;
    cas_d  = cas_q;
    stat_d = stat_q;
    unique case (st_q)
      TCS_IDLE: begin
        if (req) begin
          st_d  = TCS_ACK;
          dat_d = `TCS_RESET_WORD;
          unique case (wb_adr_i)
            `TCS_OFF_CHG0: dat_d[7:0] = chg0;
            `TCS_OFF_CHG1: dat_d[7:0] = chg1;
            `TCS_OFF_CHG2: dat_d[7:0] = chg2;
            // low bits are e1 only and read zero here
            `TCS_OFF_FRAME: dat_d[`TCS_IN_FRAME_BIT] = in_frame;
            `TCS_OFF_IRQ_STAT: begin
              dat_d[2:0] = stat_q;
              if (wr_stb) begin
                stat_d = stat_q & ~wb_dat_i[2:0];
              end
            end
            `TCS_OFF_IRQ_MASK: begin
              dat_d[2:0] = mask_q;
              if (wr_stb) begin
                mask_d = wb_dat_i[2:0];
              end
            end
            `TCS_OFF_SIG_CFG: begin
              dat_d[`TCS_CAS_BIT] = cas_q;
              if (wr_stb) begin
                cas_d = wb_dat_i[`TCS_CAS_BIT];
              end
            end
            default: begin
              err_d = 1'b1;
            end
          endcase
        end
      end
      TCS_ACK: begin
        st_d = TCS_IDLE;
      end
      default: begin
        st_d = TCS_IDLE;
      end
    endcase
    // events win over a write-one clear
    stat_d = stat_d | ev;
  end

  always_comb begin
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q   <= TCS_IDLE;
      dat_q  <= `TCS_RESET_WORD;
      err_q  <= 1'b0;
      stat_q <= '0;
      mask_q <= '0;
      cas_q  <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      dat_q  <= dat_d;
      err_q  <= err_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      cas_q  <= cas_d;
      irq_q  <= irq_d;
    end
  end

  logic ack_q;
  logic ack_d;
  always_comb begin
    ack_d = req & ~err_d;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  assign wb_dat_o   = dat_q;
  assign wb_ack_o   = ack_q;
  assign wb_err_o   = err_q;
  assign cas_mode_o = cas_q;
  assign irq_o      = irq_q;
endmodule : tcs_status_regs

// [shared/tcs_cfg.svh]
// register offsets, field positions and reset values for the cas change and frame status block
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
`define TCS_ADDR_W        12
`define TCS_OFF_CHG0      12'h0_10D
`define TCS_OFF_CHG1      12'h0_10E
`define TCS_OFF_CHG2      12'h0_10F
`define TCS_OFF_FRAME     12'h0_113
`define TCS_OFF_IRQ_STAT  12'h0_120
`define TCS_OFF_IRQ_MASK  12'h0_121
`define TCS_OFF_SIG_CFG   12'h0_122
`define TCS_IN_FRAME_BIT  7
`define TCS_IRQ_CHG_BIT   0
`define TCS_IRQ_LOF_BIT   1
`define TCS_IRQ_INF_BIT   2
`define TCS_CAS_BIT       0
`define TCS_SLOTS         24
`define TCS_SLOTS_PER_REG 8
`define TCS_RESET_BYTE    8'h00
`define TCS_RESET_WORD    32'h0000_0000
`endif

// [shared/tcs_pkg.sv]
// types shared by the cas change and frame status block
package tcs_pkg;
  typedef enum logic [1:0] {
    TCS_IDLE,
    TCS_ACK
  } tcs_bus_state_t;
  typedef logic [7:0] tcs_byte_t;
endpackage : tcs_pkg

// [shared/tcs_rd_if.sv]
// read strobe and read data path between the bus slave and the flag bank
interface tcs_rd_if;
  logic        rd_chg0;
  logic        rd_chg1;
  logic        rd_chg2;
  logic [23:0] flags;
  modport slave (output rd_chg0, output rd_chg1, output rd_chg2, input flags);
  modport bank  (input rd_chg0, input rd_chg1, input rd_chg2, output flags);
endinterface : tcs_rd_if

// [verification/t1_cas_change_and_frame_status_tb.sv]
// bench for the cas change and frame status register bank
`include "tcs_cfg.svh"
module t1_cas_change_and_frame_status_tb;
  import tcs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [23:0] chg = 24'h00_0000;
  logic        inf = 1'b0;
  wire         cyc, stb, we, ack, err, cas, irq;
  wire  [11:0] adr;
  wire  [3:0]  sel;
  wire  [31:0] wd, rdt;
  int          failures = 0;
  int          check_count = 0;
  always #12.5 clk_i = ~clk_i;
  tcs_host u_host (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(rdt), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
  tcs_status_regs #(.SLOTS(24)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdt), .wb_ack_o(ack),
    .wb_err_o(err), .sig_change_i(chg), .in_frame_i(inf), .cas_mode_o(cas), .irq_o(irq));
  task automatic test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      failures++;
    end
  endtask : chk
  task automatic go(input logic w, input logic [11:0] a, input logic [31:0] d);
    u_host.acc(w, a, d);
    if (u_host.tmo_q) begin
      failures++;
      test_done();
    end
  endtask : go
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    go(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), e, u_host.rd_q);
  endtask : rd
  task automatic pulse(input logic [23:0] v);
    chg <= v;
    @(posedge clk_i);
    chg <= 24'h00_0000;
    @(posedge clk_i);
  endtask : pulse
  task automatic t_cas_off;
    pulse(24'hFF_FFFF);
    for (int i = 0; i < 3; i++) rd(12'(`TCS_OFF_CHG0 + i), 32'h0000_0000);
    rd(`TCS_OFF_FRAME, 32'h0000_0000);
  endtask : t_cas_off
  task automatic t_map;
    go(1'b1, `TCS_OFF_SIG_CFG, 32'h0000_0001);
    chk("cas", 32'h0000_0001, {31'h0, cas});
    for (int s = 0; s < 24; s++) begin
      pulse(24'h00_0001 << s);
      rd(12'(`TCS_OFF_CHG0 + s / 8), 32'h0000_0080 >> (s % 8));
      rd(12'(`TCS_OFF_CHG0 + s / 8), 32'h0000_0000);
    end
  endtask : t_map
  task automatic t_race;
    fork
      go(1'b0, `TCS_OFF_CHG0, 32'h0000_0000);
      pulse(24'h00_0001);
    join
    chk("race", 32'h0000_0000, u_host.rd_q);
    rd(`TCS_OFF_CHG0, 32'h0000_0080);
  endtask : t_race
  task automatic t_cas_drop;
    pulse(24'h00_0100);
    go(1'b1, `TCS_OFF_SIG_CFG, 32'h0000_0000);
    chk("cas", 32'h0000_0000, {31'h0, cas});
    rd(`TCS_OFF_CHG1, 32'h0000_0000);
  endtask : t_cas_drop
  task automatic t_frame_irq;
    rd(`TCS_OFF_IRQ_STAT, 32'h0000_0001);
    go(1'b1, `TCS_OFF_IRQ_STAT, 32'h0000_0007);
    go(1'b1, `TCS_OFF_IRQ_MASK, 32'h0000_0002);
    inf <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(`TCS_OFF_FRAME, 32'h0000_0080);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    inf <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    rd(`TCS_OFF_IRQ_STAT, 32'h0000_0006);
    rd(`TCS_OFF_FRAME, 32'h0000_0000);
    go(1'b1, `TCS_OFF_IRQ_MASK, 32'h0000_0000);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    go(1'b1, `TCS_OFF_IRQ_STAT, 32'h0000_0006);
    rd(`TCS_OFF_IRQ_STAT, 32'h0000_0000);
    go(1'b0, 12'h0FF, 32'h0000_0000);
    chk("err", 32'h0000_0001, {31'h0, u_host.err_q});
  endtask : t_frame_irq
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_cas_off();
    t_map();
    t_race();
    t_cas_drop();
    t_frame_irq();
    test_done();
  end
endmodule : t1_cas_change_and_frame_status_tb

// [verification/tcs_host_model.sv]
// wishbone host reaching the status registers
module tcs_host
  import tcs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o = 1'b0,
  output logic             stb_o = 1'b0,
  output logic             we_o = 1'b0,
  output logic [11:0]      adr_o = 12'h000,
  output logic [3:0]       sel_o = 4'h0,
  output logic [31:0]      dat_o = 32'h0000_0000
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        err_q;
  logic        tmo_q;
  logic [31:0] rd_q;
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h1;
    dat_o <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ack_i || err_i) && n < 64);
    tmo_q = !(ack_i || err_i);
    err_q = err_i;
    rd_q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released data toggles so a stale value is never mistaken for valid
    dat_o <= ~d;
    @(posedge clk_i);
  endtask : acc
endmodule : tcs_host

// [verification/tcs_status_regs_assertions.sv]
// checker for the cas change and frame status register bank
`include "tcs_cfg.svh"
module tcs_chk
  import tcs_pkg::*;
(
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [`TCS_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire logic                   wb_err_o,
  input wire logic                   in_frame_i,
  input wire logic                   cas_mode_o,
  input wire logic                   irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire rd = wb_ack_o && !wb_we_i;
  wire wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_latency_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o != wb_err_o)
    else $error("no single answer");
  err_unmapped_a: assert property ($rose(wb_cyc_i && wb_stb_i) && wb_adr_i == 12'h0FF |=> wb_err_o)
    else $error("unmapped not refused");
  // input held three samples so the two-cycle register delay cannot matter
  frame_bit_a: assert property (rd && wb_adr_i == `TCS_OFF_FRAME && $stable(in_frame_i) &&
    $past(in_frame_i, 2) == in_frame_i |-> wb_dat_o[7] == in_frame_i) else $error("frame bit wrong");
  frame_rsvd_a: assert property (rd && wb_adr_i == `TCS_OFF_FRAME |-> wb_dat_o[6:0] == 7'h00)
    else $error("reserved bits set");
  chg_idle_a: assert property (rd && !cas_mode_o && wb_adr_i inside {`TCS_OFF_CHG0, `TCS_OFF_CHG1,
    `TCS_OFF_CHG2} |-> wb_dat_o[7:0] == 8'h00) else $error("flag outside cas");
  mask_off_a: assert property (wr && wb_adr_i == `TCS_OFF_IRQ_MASK && wb_dat_i[2:0] == 3'h0 |=> !irq_o)
    else $error("masked irq high");
  cas_cfg_a: assert property (wr && wb_adr_i == `TCS_OFF_SIG_CFG |=> ##1 cas_mode_o == $past(wb_dat_i[0], 2))
    else $error("cas mode wrong");
endmodule : tcs_chk
bind tcs_status_regs tcs_chk u_chk (.*);
